// ---- rtl/sioe_top.sv ----
// Purpose: 16-bit remote I/O expander with two 8-bit ports behind a bus slave.
// Assumes: 40 MHz clk_in; all pins asynchronous to it; bus up to 400 kHz.
// Notes: Pin levels pass three flops; a change counts once stages two and three agree.
// Operation
// - Sixteen I/O lines in two eight-bit ports, controlled over the serial bus.
// - Each port has direction, input, output and polarity registers.
// - After reset every line is an input with its driver off.
// - Each direction bit sets its own line to input or output.
// - Input register shows pin levels; output register latches until rewritten.
// - Set polarity bit inverts that line as read from the input register.
// - Every register can be read back over the bus.
// - Reset restores register defaults and the bus state machine.
// - Interrupt asserts while any input line differs from its captured state.
// - Interrupt pin is open drain, pulled low when asserted.
// - Three select pins form the low address bits; eight devices share a bus.
// - Slave only; changes are reported by the interrupt line.
// - Bus works at clock rates up to fast mode.
// - Address 0x20 to 0x27; address LSB high reads, low writes.
// - First written byte is the command; low three bits pick the register.
// - Register pointer persists; reads use it until a new command.
// - Bus writes to input registers are ignored.
`timescale 1ns/10ps
`default_nettype none
module sioe_top
  import sioe_pkg::*;
#(
  parameter int PORT_W = 8 // Lines per port
)
(
  input wire logic clk_in,                        // System clock, 40 MHz
  input wire logic rst_n_in,                      // Async reset, active low
  input wire logic scl_in,                        // Bus clock pin
  input wire logic sda_in,                        // Bus data pin level
  output logic sda_out,                           // Bus data drive value
  output logic sda_oe_out,                        // Bus data drive enable
  input wire logic addr_select_bit0_in,           // Address select 0
  input wire logic addr_select_bit1_in,           // Address select 1
  input wire logic addr_select_bit2_in,           // Address select 2
  input wire logic [PORT_W-1:0] port_zero_lines_in,     // Port 0 pin levels
  output logic [PORT_W-1:0] port_zero_lines_out,        // Port 0 drive values
  output logic [PORT_W-1:0] port_zero_lines_oe_out,     // Port 0 drive enables
  input wire logic [PORT_W-1:0] port_one_lines_in,      // Port 1 pin levels
  output logic [PORT_W-1:0] port_one_lines_out,         // Port 1 drive values
  output logic [PORT_W-1:0] port_one_lines_oe_out,      // Port 1 drive enables
  output logic int_n_out,                         // Interrupt drive value
  output logic int_oe_out                         // Interrupt drive enable
);

  localparam int SYNC_W = 2 * PORT_W + 5;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] filt;
  logic [SYNC_W-1:0] agree;
  logic [PORT_W-1:0] pin0;
  logic [PORT_W-1:0] pin1;
  logic scl_f;
  logic sda_f;
  logic [2:0] addr_sel;
  logic [6:0] dev_addr;

  logic [2:0] ptr;
  logic [PORT_W-1:0] out0;
  logic [PORT_W-1:0] out1;
  logic [PORT_W-1:0] pol0;
  logic [PORT_W-1:0] pol1;
  logic [PORT_W-1:0] dir0;
  logic [PORT_W-1:0] dir1;
  logic [PORT_W-1:0] snap0;
  logic [PORT_W-1:0] snap1;
  logic [2:0] prime_cnt;
  logic primed;
  logic [PORT_W-1:0] diff0;
  logic [PORT_W-1:0] diff1;

  logic [7:0] rd_data;
  logic [7:0] rx_byte;
  logic cmd_stb;
  logic wr_stb;
  logic rd_stb;
  logic slave_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers with agreement filter
  assign raw_in = {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in,
                   sda_in, scl_in, port_one_lines_in, port_zero_lines_in};
  assign agree = ~(sync2 ^ sync3);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync3 & agree) | (filt & ~agree);
    end
  end

  assign pin0 = filt[PORT_W-1:0];
  assign pin1 = filt[2*PORT_W-1:PORT_W];
  assign scl_f = filt[2*PORT_W];
  assign sda_f = filt[2*PORT_W+1];
  assign addr_sel = filt[2*PORT_W+4:2*PORT_W+2];
  assign dev_addr = {SIOE_ADDR_HI, addr_sel};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave; it only answers and never opens a transfer
  sioe_i2c_slave u_slave
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_f),
    .sda_in(sda_f),
    .dev_addr_in(dev_addr),
    .rd_data_in(rd_data),
    .sda_oe_out(slave_oe),
    .cmd_stb_out(cmd_stb),
    .wr_stb_out(wr_stb),
    .rd_stb_out(rd_stb),
    .rx_byte_out(rx_byte)
  );

  assign sda_out = 1'b0;
  assign sda_oe_out = slave_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Register pointer; kept across transfers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ptr <= SIOE_REG_IN0;
    end
    else if (cmd_stb)
    begin
      ptr <= rx_byte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers; input codes fall to default and are dropped
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      out0 <= SIOE_OUT_RST;
      out1 <= SIOE_OUT_RST;
      pol0 <= SIOE_POL_RST;
      pol1 <= SIOE_POL_RST;
      dir0 <= SIOE_DIR_RST;
      dir1 <= SIOE_DIR_RST;
    end
    else if (wr_stb)
    begin
      case (ptr)
        SIOE_REG_OUT0: out0 <= rx_byte;
        SIOE_REG_OUT1: out1 <= rx_byte;
        SIOE_REG_POL0: pol0 <= rx_byte;
        SIOE_REG_POL1: pol1 <= rx_byte;
        SIOE_REG_DIR0: dir0 <= rx_byte;
        SIOE_REG_DIR1: dir1 <= rx_byte;
        default: ;
      endcase
    end
  end

  // Direction bit one keeps the driver off
  assign port_zero_lines_out = out0;
  assign port_one_lines_out = out1;
  assign port_zero_lines_oe_out = ~dir0;
  assign port_one_lines_oe_out = ~dir1;

  ////////////////////////////////////////////////////////////////////////////
  // Read-back mux; input ports show live levels through polarity
  always_comb
  begin
    rd_data = 8'h00;
    case (ptr)
      SIOE_REG_IN0: rd_data = pin0 ^ pol0;
      SIOE_REG_IN1: rd_data = pin1 ^ pol1;
      SIOE_REG_OUT0: rd_data = out0;
      SIOE_REG_OUT1: rd_data = out1;
      SIOE_REG_POL0: rd_data = pol0;
      SIOE_REG_POL1: rd_data = pol1;
      SIOE_REG_DIR0: rd_data = dir0;
      SIOE_REG_DIR1: rd_data = dir1;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection. Snapshots wait for the synchronisers to fill after
  // reset, otherwise the first real levels would look like a change.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prime_cnt <= 3'h0;
    end
    else if (!primed)
    begin
      prime_cnt <= prime_cnt + 3'h1;
    end
  end

  assign primed = (prime_cnt == SIOE_PRIME_CYCLES);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      snap0 <= '0;
      snap1 <= '0;
    end
    else
    begin
      if (!primed || (rd_stb && ptr == SIOE_REG_IN0))
      begin
        snap0 <= pin0;
      end
      if (!primed || (rd_stb && ptr == SIOE_REG_IN1))
      begin
        snap1 <= pin1;
      end
    end
  end

  // Output-configured lines never raise the interrupt
  assign diff0 = (pin0 ^ snap0) & dir0;
  assign diff1 = (pin1 ^ snap1) & dir1;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      int_oe_out <= 1'b0;
    end
    else
    begin
      int_oe_out <= primed & ((|diff0) | (|diff1));
    end
  end

  // Open drain: only ever drives low
  assign int_n_out = 1'b0;

endmodule
`default_nettype wire

// ---- rtl/sioe_pkg.sv ----
// Purpose: Shared constants and types for the 16-bit serial I/O expander.
// Assumes: Two-wire bus slave on a single 40 MHz clock.
// Notes: Register codes follow the command byte low three bits.
package sioe_pkg;

  // Fixed upper address bits; the three select pins complete the 7-bit address
  localparam logic [3:0] SIOE_ADDR_HI = 4'h4;

  // Command byte register codes
  localparam logic [2:0] SIOE_REG_IN0 = 3'h0;
  localparam logic [2:0] SIOE_REG_IN1 = 3'h1;
  localparam logic [2:0] SIOE_REG_OUT0 = 3'h2;
  localparam logic [2:0] SIOE_REG_OUT1 = 3'h3;
  localparam logic [2:0] SIOE_REG_POL0 = 3'h4;
  localparam logic [2:0] SIOE_REG_POL1 = 3'h5;
  localparam logic [2:0] SIOE_REG_DIR0 = 3'h6;
  localparam logic [2:0] SIOE_REG_DIR1 = 3'h7;

  // Reset values; a direction bit of one means input
  localparam logic [7:0] SIOE_OUT_RST = 8'hff;
  localparam logic [7:0] SIOE_POL_RST = 8'h00;
  localparam logic [7:0] SIOE_DIR_RST = 8'hff;

  // Bits in one bus byte
  localparam logic [3:0] SIOE_BYTE_BITS = 4'h8;
  localparam logic [3:0] SIOE_LAST_BIT = 4'h7;

  // Cycles after reset before pin snapshots are trusted: three sync stages and
  // the agreement stage, plus one so the last snapshot sees settled levels
  localparam logic [2:0] SIOE_PRIME_CYCLES = 3'h5;

  typedef enum logic [4:0] {
    SIOE_IDLE = 5'h01,
    SIOE_RX = 5'h02,
    SIOE_ACK = 5'h04,
    SIOE_TX = 5'h08,
    SIOE_TXACK = 5'h10
  } sioe_state_t;

endpackage

// ---- rtl/sioe_i2c_slave.sv ----
// Purpose: Two-wire bus slave engine: address match, byte receive, byte transmit.
// Assumes: scl_in and sda_in are already synchronised and filtered.
// Notes: Never stretches the clock; only pulls the data line low.
`timescale 1ns/10ps
`default_nettype none
module sioe_i2c_slave
  import sioe_pkg::*;
(
  input wire logic clk_in,          // System clock
  input wire logic rst_n_in,        // Async reset, active low
  input wire logic scl_in,          // Filtered bus clock level
  input wire logic sda_in,          // Filtered bus data level
  input wire logic [6:0] dev_addr_in, // Own 7-bit address
  input wire logic [7:0] rd_data_in, // Byte to send on a read
  output logic sda_oe_out,          // High pulls data line low
  output logic cmd_stb_out,         // Command byte received
  output logic wr_stb_out,          // Data byte received
  output logic rd_stb_out,          // Read byte loaded
  output logic [7:0] rx_byte_out    // Last received byte
);

  sioe_state_t state;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic is_addr;
  logic first_data;
  logic rw;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer; start or stop anywhere restarts it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= SIOE_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      is_addr <= 1'b0;
      first_data <= 1'b0;
      rw <= 1'b0;
      sda_oe_out <= 1'b0;
      cmd_stb_out <= 1'b0;
      wr_stb_out <= 1'b0;
      rd_stb_out <= 1'b0;
      rx_byte_out <= 8'h00;
    end
    else
    begin
      cmd_stb_out <= 1'b0;
      wr_stb_out <= 1'b0;
      rd_stb_out <= 1'b0;
      if (start_seen)
      begin
        state <= SIOE_RX;
        bit_cnt <= 4'h0;
        is_addr <= 1'b1;
        sda_oe_out <= 1'b0;
      end
      else if (stop_seen)
      begin
        state <= SIOE_IDLE;
        sda_oe_out <= 1'b0;
      end
      else
      begin
        case (state)
          SIOE_RX:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == SIOE_BYTE_BITS)
            begin
              bit_cnt <= 4'h0;
              is_addr <= 1'b0;
              if (is_addr)
              begin
                // General call and foreign addresses are left alone
                if (shreg[7:1] == dev_addr_in)
                begin
                  rw <= shreg[0];
                  first_data <= ~shreg[0];
                  sda_oe_out <= 1'b1;
                  state <= SIOE_ACK;
                end
                else
                begin
                  state <= SIOE_IDLE;
                end
              end
              else
              begin
                rx_byte_out <= shreg;
                cmd_stb_out <= first_data;
                wr_stb_out <= ~first_data;
                first_data <= 1'b0;
                sda_oe_out <= 1'b1;
                state <= SIOE_ACK;
              end
            end
          end
          SIOE_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (rw)
              begin
                txreg <= rd_data_in;
                sda_oe_out <= ~rd_data_in[7];
                rd_stb_out <= 1'b1;
                state <= SIOE_TX;
              end
              else
              begin
                sda_oe_out <= 1'b0;
                state <= SIOE_RX;
              end
            end
          end
          SIOE_TX:
          begin
            if (scl_fall)
            begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == SIOE_LAST_BIT)
              begin
                sda_oe_out <= 1'b0;
                state <= SIOE_TXACK;
              end
              else
              begin
                sda_oe_out <= ~txreg[6];
                txreg <= {txreg[6:0], 1'b0};
              end
            end
          end
          SIOE_TXACK:
          begin
            // Master ack sends another byte; a nack ends our part
            if (scl_rise)
            begin
              state <= sda_in ? SIOE_IDLE : SIOE_ACK;
            end
          end
          default:
          begin
            state <= SIOE_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- sim/sioe_top_chk.sv ----
// Purpose: Port-level assertions for the I/O expander top.
// Assumes: Bound into sioe_top; one clock domain.
// Notes: Bus answer bounds follow the three-flop pin synchronisers.
`timescale 1ns/10ps
`default_nettype none
module sioe_top_chk
  import sioe_pkg::*;
#(
  parameter int PORT_W = 8 // Lines per port
)
(
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_in, // Bus data wire
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe_out, // Data drive enable
  input wire logic addr_select_bit0_in, // Strap 0
  input wire logic addr_select_bit1_in, // Strap 1
  input wire logic addr_select_bit2_in, // Strap 2
  input wire logic [PORT_W-1:0] port_zero_lines_in, // Port 0 pins
  input wire logic [PORT_W-1:0] port_zero_lines_out, // Port 0 drive
  input wire logic [PORT_W-1:0] port_zero_lines_oe_out, // Port 0 enables
  input wire logic [PORT_W-1:0] port_one_lines_in, // Port 1 pins
  input wire logic [PORT_W-1:0] port_one_lines_out, // Port 1 drive
  input wire logic [PORT_W-1:0] port_one_lines_oe_out, // Port 1 enables
  input wire logic int_n_out, // Interrupt value
  input wire logic int_oe_out // Interrupt enable
);
  // Cycles since a pin level or a direction last moved
  logic [3:0] quiet;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      quiet <= 4'h0;
    else if ($changed({port_zero_lines_in, port_one_lines_in, port_zero_lines_oe_out, port_one_lines_oe_out}))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_sda_val; sda_out == 1'b0; endproperty
  a_sda_val: assert property (p_sda_val) else $error("data drive value not low");
  property p_int_val; int_n_out == 1'b0; endproperty
  a_int_val: assert property (p_int_val) else $error("interrupt drive value not low");
  property p_rst;
    $rose(rst_n_in) |-> port_zero_lines_oe_out == '0 && port_one_lines_oe_out == '0 &&
      port_zero_lines_out == '1 && port_one_lines_out == '1 && !int_oe_out && !sda_oe_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset state");
  property p_chg0; $changed({port_zero_lines_oe_out, port_zero_lines_out}) |-> !scl_in; endproperty
  a_chg0: assert property (p_chg0) else $error("port 0 changed outside a bus write");
  property p_chg1; $changed({port_one_lines_oe_out, port_one_lines_out}) |-> !scl_in; endproperty
  a_chg1: assert property (p_chg1) else $error("port 1 changed outside a bus write");
  // Slave changes its drive only in the low clock phase, so it can never fake a start or stop
  property p_sda_rise; $rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 2) && $past(scl_in, 7); endproperty
  a_sda_rise: assert property (p_sda_rise) else $error("data pulled low at wrong time");
  property p_sda_fall; $fell(sda_oe_out) |-> !scl_in; endproperty
  a_sda_fall: assert property (p_sda_fall) else $error("data released while clock high");
  property p_int_rise; $rose(int_oe_out) |-> quiet < 4'hc; endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt without input change");
endmodule
`default_nettype wire

// ---- sim/sioe_master.sv ----
// Purpose: Behavioural two-wire bus master facing the expander.
// Assumes: Bit period of 100 clocks, 400 kHz at 40 MHz.
// Notes: Clock stands high between frames; data line relies on the pull-up.
`timescale 1ns/10ps
`default_nettype none
module sioe_master (
  input wire logic clk_in, // System clock
  input wire logic sda_in, // Resolved data wire
  output logic scl_out, // Bus clock
  output logic sda_oe_out // High pulls data low
);
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic q;
    repeat (25) @(posedge clk_in);
  endtask

  task automatic start;
    sda_oe_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask

  task automatic stop;
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b0;
    q();
  endtask

  // Eight bits MSB first then the ack slot; ack_drv pulls the ack low
  task automatic xfer(input logic [7:0] tx, input logic ack_drv, output logic [7:0] rx, output logic ack);
    logic [8:0] s;
    logic [8:0] r;
    s = {tx, ~ack_drv};
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_out <= ~s[i];
      q();
      scl_out <= 1'b1;
      q();
      r[i] = sda_in;
      q();
      scl_out <= 1'b0;
      q();
    end
    rx = r[8:1];
    ack = ~r[0];
  endtask
endmodule
`default_nettype wire

// ---- sim/sioe_top_test.sv ----
// Purpose: Self-checking bench for the I/O expander top.
// Assumes: Master model on the bus; pins resolve drive over external level.
// Notes: Register model lives in the bench and predicts every read.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module sioe_top_test;
  logic clk_in, rst_n_in, scl_in, sda_in, sda_out, sda_oe_out, m_sda_oe, int_n_out, int_oe_out;
  logic addr_select_bit0_in, addr_select_bit1_in, addr_select_bit2_in;
  logic [7:0] port_zero_lines_in, port_zero_lines_out, port_zero_lines_oe_out, ext0;
  logic [7:0] port_one_lines_in, port_one_lines_out, port_one_lines_oe_out, ext1;
  logic [7:0] m [8];
  logic [2:0] ptr, strap;
  int n_mismatch = 0;
  int tests_run = 0;

  assign {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in} = strap;
  assign sda_in = ~(sda_oe_out | m_sda_oe);
  assign port_zero_lines_in = (port_zero_lines_oe_out & port_zero_lines_out) | (~port_zero_lines_oe_out & ext0);
  assign port_one_lines_in = (port_one_lines_oe_out & port_one_lines_out) | (~port_one_lines_oe_out & ext1);

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  sioe_top #(.PORT_W(8)) u_dut (.clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .addr_select_bit0_in, .addr_select_bit1_in, .addr_select_bit2_in, .port_zero_lines_in,
    .port_zero_lines_out, .port_zero_lines_oe_out, .port_one_lines_in, .port_one_lines_out,
    .port_one_lines_oe_out, .int_n_out, .int_oe_out);
  sioe_master u_master (.clk_in, .sda_in, .scl_out(scl_in), .sda_oe_out(m_sda_oe));

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] expv(input logic [2:0] c);
    logic [7:0] p0;
    logic [7:0] p1;
    p0 = (~m[6] & m[2]) | (m[6] & ext0);
    p1 = (~m[7] & m[3]) | (m[7] & ext1);
    if (c == 3'h0)
      return p0 ^ m[4];
    if (c == 3'h1)
      return p1 ^ m[5];
    return m[c];
  endfunction

  task automatic addr(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic ack;
    u_master.start();
    u_master.xfer(b, 1'b0, rx, ack);
    `CHK(ack, exp_ack)
  endtask

  task automatic wr(input logic [2:0] c, input logic [7:0] d, input logic has_d);
    logic [7:0] rx;
    logic ack;
    addr({4'h4, strap, 1'b0}, 1'b1);
    u_master.xfer({d[4:0], c}, 1'b0, rx, ack);
    `CHK(ack, 1'b1)
    ptr = c;
    if (has_d)
    begin
      u_master.xfer(d, 1'b0, rx, ack);
      `CHK(ack, 1'b1)
      if (c > 3'h1)
        m[c] = d;
    end
    u_master.stop();
  endtask

  task automatic rd(input int n);
    logic [7:0] rx;
    logic ack;
    addr({4'h4, strap, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      u_master.xfer(8'hff, k < n - 1, rx, ack);
      `CHK(rx, expv(ptr))
    end
    u_master.stop();
  endtask

  task automatic chk_reset;
    `CHK({port_zero_lines_oe_out, port_one_lines_oe_out}, 16'h0000)
    `CHK({port_zero_lines_out, port_one_lines_out}, 16'hffff)
    `CHK(int_oe_out, 1'b0)
  endtask

  task automatic wait_int(input logic e);
    repeat (12) @(posedge clk_in);
    `CHK(int_oe_out, e)
  endtask

  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Normal run is about 88k cycles
  initial
  begin
    repeat (95000) @(posedge clk_in);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h7bd0a170));
    rst_n_in = 1'b0;
    strap = 3'h0;
    ext0 = 8'($urandom);
    ext1 = 8'($urandom);
    m = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    ptr = 3'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk_reset();
    rd(2);
    for (int c = 0; c < 8; c++)
    begin
      ext0 <= 8'($urandom);
      wr(c[2:0], 8'($urandom), 1'b1);
      rd(2);
      `CHK({port_zero_lines_oe_out, port_one_lines_oe_out}, ~{m[6], m[7]})
      `CHK({port_zero_lines_out, port_one_lines_out}, {m[2], m[3]})
    end
    for (int a = 0; a < 8; a++)
    begin
      strap <= a[2:0];
      @(posedge clk_in);
      addr({4'h4, a[2:0], 1'b0}, 1'b1);
      u_master.stop();
      addr({4'h4, a[2:0] + 3'h1, 1'b0}, 1'b0);
      u_master.stop();
    end
    addr(8'h00, 1'b0);
    u_master.stop();
    wr(3'h6, 8'hff, 1'b1);
    wr(3'h7, 8'hff, 1'b1);
    wr(3'h1, 8'h00, 1'b0);
    rd(1);
    wr(3'h0, 8'h00, 1'b0);
    rd(1);
    wait_int(1'b0);
    ext1 <= ext1 ^ 8'h81;
    wait_int(1'b1);
    `CHK(int_n_out, 1'b0)
    ext1 <= ext1 ^ 8'h81;
    wait_int(1'b0);
    ext0 <= ext0 ^ 8'h02;
    wait_int(1'b1);
    rd(1);
    wait_int(1'b0);
    wr(3'h3, 8'h3c, 1'b1);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    m = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    ptr = 3'h0;
    repeat (10) @(posedge clk_in);
    chk_reset();
    rd(1);
    end_of_test();
  end
endmodule

bind sioe_top sioe_top_chk #(.PORT_W(PORT_W)) u_chk (.clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .addr_select_bit0_in, .addr_select_bit1_in, .addr_select_bit2_in, .port_zero_lines_in,
  .port_zero_lines_out, .port_zero_lines_oe_out, .port_one_lines_in, .port_one_lines_out,
  .port_one_lines_oe_out, .int_n_out, .int_oe_out);
`default_nettype wire
